// ### ref_select_ctrl.v
//
// Overview of operation
// - selected-reference status shows high for input a, low for input b
// - status choices include active-low holdover and active-low lock indicator levels
// - control bit 7 set bypasses switchover deglitch; clear keeps deglitching
// - manual register mode: bit 6 clear picks input a, set picks b
// - bit 5 clear uses register select bit, set follows select pin
// - bit 4 set enables automatic switchover; software keeps single-ended mode then
// - automatic switchover powers both inputs, overriding enable bits
// - after auto switch to b, bit 3 clear reverts when a is good
// - bits 2 and 1 power inputs b and a, ignored during auto
// - bit 0 selects single-ended (clear) or differential (set) input mode
//
`timescale 1ns/100ps
`include "refsel_regs.vh"
module ref_select_ctrl (
    input  wire        MCLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        REF_SELECT_PIN,
    input  wire        REF_A_GOOD,
    input  wire        REF_B_GOOD,
    input  wire        PLL_LOCKED,
    output reg         USE_REF_B,
    output reg         DIFF_MODE,
    output reg         REF_A_POWER,
    output reg         REF_B_POWER,
    output reg         SWITCH_MUTE,
    output reg         HOLDOVER,
    output reg         STATUS_OUT,
    output reg         IRQ
);
    ////////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 2'b00;
    localparam ST_MUTE = 2'b01;

    reg  [7:0]  ctrl;
    reg  [5:0]  status_sel;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;

    // selection and deglitch state
    reg  [1:0]  state;
    reg  [3:0]  mute_cnt;
    reg         auto_on_b;
    reg         want_b;
    reg         lock_seen;

    // pin levels after the two-flop synchroniser
    wire [2:0]  ext_sync;
    wire        pin_sel     = ext_sync[0];
    wire        a_good      = ext_sync[1];
    wire        b_good      = ext_sync[2];

    // lock level is a pin as well, so it gets its own two flops
    reg         lock_q1;
    reg         lock_q2;

    // combinational next values
    reg         next_want_b;
    reg         next_status;
    reg  [2:0]  events;
    reg  [31:0] next_rdata;

    wire access   = PSEL & PENABLE & PREADY;
    wire wr_cycle = access & PWRITE;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `ADDR_REF_SEL_CTRL) || (a == `ADDR_STATUS_SEL) ||
                     (a == `ADDR_IRQ_STATUS) || (a == `ADDR_IRQ_MASK) ||
                     (a == `ADDR_LIVE_STATE);
        end
    endfunction

    // pin-level inputs cross in through two flops before anything reads them
    sync2 #(.WIDTH(3)) u_sync (
        .MCLK  (MCLK),
        .RESET (RESET),
        .d     ({REF_B_GOOD, REF_A_GOOD, REF_SELECT_PIN}),
        .q     (ext_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state so every answer comes from a flop
    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PRDATA  <= next_rdata;
            // unmapped address still answers, flagged so the master knows
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped(PADDR);
        end
    end

    always @*
    begin
        next_rdata = 32'h00000000;
        case (PADDR)
            `ADDR_REF_SEL_CTRL: next_rdata = {24'h000000, ctrl};
            `ADDR_STATUS_SEL:   next_rdata = {26'h0000000, status_sel};
            `ADDR_IRQ_STATUS:   next_rdata = {29'h00000000, irq_status};
            `ADDR_IRQ_MASK:     next_rdata = {29'h00000000, irq_mask};
            `ADDR_LIVE_STATE:   next_rdata = {27'h0000000, lock_q2, HOLDOVER,
                                              b_good, a_good, USE_REF_B};
            default:            next_rdata = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // writes land only on the edge that samples PREADY high
    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            ctrl       <= `RST_REF_SEL_CTRL;
            status_sel <= {3'h0, `RST_STATUS_SEL};
            irq_mask   <= `RST_IRQ_MASK;
        end
        else if (wr_cycle)
        begin
            if (PADDR == `ADDR_REF_SEL_CTRL)
                ctrl <= PWDATA[7:0];
            if (PADDR == `ADDR_STATUS_SEL)
                status_sel <= PWDATA[5:0];
            if (PADDR == `ADDR_IRQ_MASK)
                irq_mask <= PWDATA[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference choice
    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            lock_q1 <= 1'b0;
            lock_q2 <= 1'b0;
        end
        else
        begin
            lock_q1 <= PLL_LOCKED;
            lock_q2 <= lock_q1;
        end
    end

    // priority: differential mode, then auto, then pin, then register bit
    always @*
    begin
        if (ctrl[`BIT_DIFF_MODE])
            next_want_b = 1'b0;
        else if (ctrl[`BIT_AUTO_SW])
        begin
            if (!auto_on_b)
                next_want_b = ~a_good & b_good;
            else if (!ctrl[`BIT_STAY_B] && a_good)
                next_want_b = 1'b0;
            else
                next_want_b = 1'b1;
        end
        else if (ctrl[`BIT_USE_PIN])
            next_want_b = pin_sel;
        else
            next_want_b = ctrl[`BIT_SEL_B];
    end

    // deglitch: mute the reference for a settle time around a change
    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            state       <= ST_IDLE;
            mute_cnt    <= 4'h0;
            want_b      <= 1'b0;
            auto_on_b   <= 1'b0;
            USE_REF_B   <= 1'b0;
            SWITCH_MUTE <= 1'b0;
        end
        else
        begin
            want_b    <= next_want_b;
            auto_on_b <= ctrl[`BIT_AUTO_SW] & next_want_b;
            case (state)
                ST_IDLE:
                begin
                    if (want_b != USE_REF_B)
                    begin
                        if (ctrl[`BIT_NO_DEGLITCH])
                            USE_REF_B <= want_b;
                        else
                        begin
                            state       <= ST_MUTE;
                            SWITCH_MUTE <= 1'b1;
                            mute_cnt    <= `DEGLITCH_LOAD;
                        end
                    end
                end
                // a choice that changes during the mute is taken at its end
                ST_MUTE:
                begin
                    if (mute_cnt == 4'h0)
                    begin
                        USE_REF_B   <= want_b;
                        SWITCH_MUTE <= 1'b0;
                        state       <= ST_IDLE;
                    end
                    else
                        mute_cnt <= mute_cnt - 4'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power, mode, status pin
    // codes outside the three kept ones give a quiet low level
    always @*
    begin
        case (status_sel[2:0])
            `STSEL_SELECTED:   next_status = ~USE_REF_B;
            `STSEL_LOCK_N:     next_status = ~lock_q2;
            `STSEL_HOLDOVER_N: next_status = ~HOLDOVER;
            default:           next_status = 1'b0;
        endcase
        if (status_sel[5:3] != 3'h7)
            next_status = 1'b0;
    end

    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            DIFF_MODE   <= 1'b0;
            REF_A_POWER <= 1'b0;
            REF_B_POWER <= 1'b0;
            HOLDOVER    <= 1'b0;
            STATUS_OUT  <= 1'b0;
        end
        else
        begin
            DIFF_MODE   <= ctrl[`BIT_DIFF_MODE];
            // auto forces both on; limitation: diff mode with enables set is
            // left as software wrote it
            REF_A_POWER <= ctrl[`BIT_AUTO_SW] | ctrl[`BIT_PWR_A];
            REF_B_POWER <= ctrl[`BIT_AUTO_SW] | ctrl[`BIT_PWR_B];
            // holdover only when auto switchover has no good input left
            HOLDOVER    <= ctrl[`BIT_AUTO_SW] & ~a_good & ~b_good;
            STATUS_OUT  <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set beats clear
    always @*
    begin
        events                 = 3'h0;
        // a mute that ends on the old choice is no switch
        events[`IRQ_SWITCHED]  = (state == ST_IDLE) & (want_b != USE_REF_B) &
                                 ctrl[`BIT_NO_DEGLITCH] |
                                 (state == ST_MUTE) & (mute_cnt == 4'h0) &
                                 (want_b != USE_REF_B);
        events[`IRQ_HOLDOVER]  = ctrl[`BIT_AUTO_SW] & ~a_good & ~b_good & ~HOLDOVER;
        events[`IRQ_LOCK_LOST] = lock_seen & ~lock_q2;
    end

    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            irq_status <= 3'h0;
            lock_seen  <= 1'b0;
            IRQ        <= 1'b0;
        end
        else
        begin
            lock_seen <= lock_q2;
            if (wr_cycle && PADDR == `ADDR_IRQ_STATUS)
                irq_status <= (irq_status & ~PWDATA[2:0]) | events;
            else
                irq_status <= irq_status | events;
            // one cycle behind the status so the pin comes from a flop
            IRQ <= |(irq_status & irq_mask);
        end
    end
endmodule // ref_select_ctrl

// ### refsel_regs.vh
`ifndef REFSEL_REGS_VH
`define REFSEL_REGS_VH
// byte addresses on the register bus
`define ADDR_REF_SEL_CTRL   12'h01C
`define ADDR_STATUS_SEL     12'h020
`define ADDR_IRQ_STATUS     12'h024
`define ADDR_IRQ_MASK       12'h028
`define ADDR_LIVE_STATE     12'h02C
// reference_selection_control fields
`define BIT_NO_DEGLITCH     7
`define BIT_SEL_B           6
`define BIT_USE_PIN         5
`define BIT_AUTO_SW         4
`define BIT_STAY_B          3
`define BIT_PWR_B           2
`define BIT_PWR_A           1
`define BIT_DIFF_MODE       0
`define RST_REF_SEL_CTRL    8'h00
`define RST_STATUS_SEL      3'h0
`define RST_IRQ_MASK        3'h0
// status pin selector codes (low bits of the 6-bit selector)
`define STSEL_SELECTED      3'h4
`define STSEL_LOCK_N        3'h5
`define STSEL_HOLDOVER_N    3'h6
// interrupt bits
`define IRQ_SWITCHED        0
`define IRQ_HOLDOVER        1
`define IRQ_LOCK_LOST       2
// deglitch settle time in ns at 100 MHz
`define DEGLITCH_NS         80
`define CLK_NS              10
`define DEGLITCH_CYCLES     ((`DEGLITCH_NS + `CLK_NS - 1) / `CLK_NS)
// mute counter load, DEGLITCH_CYCLES - 1, sized for the 4-bit counter
`define DEGLITCH_LOAD       4'h7
`endif

// ### sync2.v
`timescale 1ns/100ps
module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             MCLK,
    input  wire             RESET,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            meta <= {WIDTH{1'b0}};
            q    <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync2

// ### ref_select_ctrl_monitor.sv
`timescale 1ns/100ps
module ref_select_ctrl_monitor (
    input wire        MCLK,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        USE_REF_B,
    input wire        DIFF_MODE,
    input wire        REF_A_POWER,
    input wire        REF_B_POWER,
    input wire        SWITCH_MUTE,
    input wire        STATUS_OUT
);
    // shadows of the control words, taken at the edge the write lands
    reg  [7:0] ctl;
    reg  [5:0] sel;
    wire       wr  = PSEL && PENABLE && PREADY && PWRITE;
    wire       bad = PADDR < 12'h01C || PADDR > 12'h02C || PADDR[1:0] != 2'h0;
    always @(posedge MCLK)
    begin
        if (RESET)
        begin
            ctl <= 8'h00;
            sel <= 6'h00;
        end
        else if (wr && PADDR == 12'h01C)
            ctl <= PWDATA[7:0];
        else if (wr && PADDR == 12'h020)
            sel <= PWDATA[5:0];
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////////
    diff_follow_a: assert property (DIFF_MODE == $past(ctl[0]))
        else $error("diff mode output wrong");
    power_a_a: assert property (REF_A_POWER == $past(ctl[4] | ctl[1]))
        else $error("input a power wrong");
    power_b_a: assert property (REF_B_POWER == $past(ctl[4] | ctl[2]))
        else $error("input b power wrong");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    ready_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    err_map_a: assert property (PREADY |-> PSLVERR == bad)
        else $error("error flag wrong");
    mute_hold_a: assert property ($rose(SWITCH_MUTE) |-> SWITCH_MUTE [*8])
        else $error("mute too short");
    // selected level only judged once selector and selection have settled
    status_sel_a: assert property (sel == 6'h3C && $past(sel) == 6'h3C
        && $stable(USE_REF_B) && USE_REF_B == $past(USE_REF_B, 2)
        |-> STATUS_OUT == !USE_REF_B) else $error("selected level wrong");
    cover property ($rose(SWITCH_MUTE));
    cover property ($rose(USE_REF_B));
    cover property (PSLVERR);
endmodule // ref_select_ctrl_monitor
bind ref_select_ctrl ref_select_ctrl_monitor u_ref_select_ctrl_monitor (
    .MCLK        (MCLK),
    .RESET       (RESET),
    .PSEL        (PSEL),
    .PENABLE     (PENABLE),
    .PWRITE      (PWRITE),
    .PADDR       (PADDR),
    .PWDATA      (PWDATA),
    .PREADY      (PREADY),
    .PSLVERR     (PSLVERR),
    .USE_REF_B   (USE_REF_B),
    .DIFF_MODE   (DIFF_MODE),
    .REF_A_POWER (REF_A_POWER),
    .REF_B_POWER (REF_B_POWER),
    .SWITCH_MUTE (SWITCH_MUTE),
    .STATUS_OUT  (STATUS_OUT)
);

// ### ref_sources.sv
`timescale 1ns/100ps
module ref_sources (
    input  wire       MCLK,
    input  wire [3:0] cmd,
    output reg        REF_A_GOOD,
    output reg        REF_B_GOOD,
    output reg        REF_SELECT_PIN,
    output reg        PLL_LOCKED
);
    // status levels change only on the clock, like the monitored sources
    always @(posedge MCLK)
        {PLL_LOCKED, REF_SELECT_PIN, REF_B_GOOD, REF_A_GOOD} <= cmd;
endmodule // ref_sources

// ### ref_select_ctrl_tb.sv
`timescale 1ns/100ps
`include "refsel_regs.vh"
module ref_select_ctrl_tb;
    reg         MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, e;
    reg  [11:0] PADDR = 12'h000;
    reg  [31:0] PWDATA = 32'h0, r, v;
    reg  [3:0]  cmd = 4'hB;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, pin, a_ok, b_ok, lock, USE_REF_B, DIFF_MODE;
    wire        REF_A_POWER, REF_B_POWER, SWITCH_MUTE, HOLDOVER, STATUS_OUT, IRQ;
    integer     error_cnt = 0, compares = 0, n, i;
    ref_sources u_ref_sources (.MCLK(MCLK), .cmd(cmd), .REF_A_GOOD(a_ok),
        .REF_B_GOOD(b_ok), .REF_SELECT_PIN(pin), .PLL_LOCKED(lock));
    ref_select_ctrl u_ref_select_ctrl (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .REF_SELECT_PIN(pin),
        .REF_A_GOOD(a_ok), .REF_B_GOOD(b_ok), .PLL_LOCKED(lock), .USE_REF_B(USE_REF_B),
        .DIFF_MODE(DIFF_MODE), .REF_A_POWER(REF_A_POWER), .REF_B_POWER(REF_B_POWER),
        .SWITCH_MUTE(SWITCH_MUTE), .HOLDOVER(HOLDOVER), .STATUS_OUT(STATUS_OUT), .IRQ(IRQ));
    initial forever #5 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////////////
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1)
            @(posedge MCLK);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    end
    endtask
    task chk(input [31:0] g, input [31:0] x);
    begin
        compares = compares + 1;
        if (g !== x)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    end
    endtask
    // sync flops plus selection flop plus the full deglitch span
    task settle;
        repeat (16) @(posedge MCLK);
    endtask
    task meas(input v);
    begin
        n = 0;
        while (USE_REF_B !== v && n < 40)
        begin
            @(posedge MCLK);
            n = n + 1;
        end
    end
    endtask
    task results;
    begin
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
    begin
        apb(0, `ADDR_REF_SEL_CTRL, 0);
        chk(r, `RST_REF_SEL_CTRL);
        apb(1, `ADDR_REF_SEL_CTRL, 32'hE6);
        apb(0, `ADDR_REF_SEL_CTRL, 0);
        chk(r, 32'hE6);
        apb(0, 12'h040, 0);
        chk(r, 0);
        chk(e, 1);
        for (i = 0; i < 4; i = i + 1)
        begin
            v = 32'h02 << i;
            apb(1, `ADDR_REF_SEL_CTRL, v);
            settle;
            chk({REF_A_POWER, REF_B_POWER}, {v[4] | v[1], v[4] | v[2]});
        end
    end
    endtask
    task t_manual;
    begin
        apb(1, `ADDR_REF_SEL_CTRL, 32'h40);
        meas(1);
        chk(n >= `DEGLITCH_CYCLES && n < 40, 1);
        apb(1, `ADDR_REF_SEL_CTRL, 32'h80);
        meas(0);
        chk(n <= 3, 1);
        apb(1, `ADDR_REF_SEL_CTRL, 32'hE0);
        settle;
        chk(USE_REF_B, 0);
        cmd[2] <= 1'b1;
        settle;
        chk(USE_REF_B, 1);
        cmd[2] <= 1'b0;
    end
    endtask
    task t_auto;
    begin
        apb(1, `ADDR_REF_SEL_CTRL, 32'h90);
        settle;
        chk(USE_REF_B, 0);
        cmd <= 4'hA;
        settle;
        chk(USE_REF_B, 1);
        cmd <= 4'hB;
        settle;
        chk(USE_REF_B, 0);
        apb(1, `ADDR_REF_SEL_CTRL, 32'h98);
        cmd <= 4'hA;
        settle;
        cmd <= 4'hB;
        settle;
        chk(USE_REF_B, 1);
        cmd <= 4'h8;
        apb(1, `ADDR_STATUS_SEL, 32'h3E);
        settle;
        chk({HOLDOVER, STATUS_OUT}, 2'b10);
        cmd <= 4'hB;
    end
    endtask
    task t_status;
    begin
        apb(1, `ADDR_REF_SEL_CTRL, 32'h80);
        apb(1, `ADDR_STATUS_SEL, 32'h3C);
        settle;
        chk(STATUS_OUT, 1);
        apb(1, `ADDR_REF_SEL_CTRL, 32'hC0);
        settle;
        chk(STATUS_OUT, 0);
        apb(1, `ADDR_STATUS_SEL, 32'h3D);
        settle;
        chk(STATUS_OUT, 0);
        cmd[3] <= 1'b0;
        settle;
        chk(STATUS_OUT, 1);
        apb(1, `ADDR_REF_SEL_CTRL, 32'hC1);
        settle;
        chk({DIFF_MODE, USE_REF_B, REF_A_POWER, REF_B_POWER}, 4'h8);
        apb(0, `ADDR_LIVE_STATE, 0);
        chk(r, 32'h06);
        apb(0, `ADDR_STATUS_SEL, 0);
        chk(r, 32'h3D);
    end
    endtask
    task t_irq;
    begin
        apb(0, `ADDR_IRQ_STATUS, 0);
        chk(r, 32'h7);
        apb(1, `ADDR_IRQ_STATUS, 32'hFFFFFFFF);
        apb(1, `ADDR_IRQ_MASK, 32'h1);
        apb(1, `ADDR_REF_SEL_CTRL, 32'h80);
        apb(1, `ADDR_REF_SEL_CTRL, 32'hC0);
        settle;
        chk(IRQ, 1);
        apb(1, `ADDR_IRQ_STATUS, 32'h1);
        settle;
        chk(IRQ, 0);
        apb(1, `ADDR_IRQ_MASK, 32'h0);
        apb(1, `ADDR_REF_SEL_CTRL, 32'h80);
        settle;
        chk(IRQ, 0);
        apb(0, `ADDR_IRQ_STATUS, 0);
        chk(r[0], 1);
    end
    endtask
    task t_reset;
    begin
        RESET <= 1'b1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        chk({USE_REF_B, SWITCH_MUTE, IRQ, STATUS_OUT}, 4'h0);
        apb(0, `ADDR_REF_SEL_CTRL, 0);
        chk(r, `RST_REF_SEL_CTRL);
        apb(0, `ADDR_STATUS_SEL, 0);
        chk(r, 0);
    end
    endtask
    initial
    begin
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        t_regs;
        t_manual;
        t_auto;
        t_status;
        t_irq;
        t_reset;
        results;
    end
    // all scenarios finish well inside this span
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        results;
    end
endmodule // ref_select_ctrl_tb
